/* common/slc_pkg.sv */
// Types shared by the lane configuration block
package slc_pkg;

  typedef struct packed {
    logic [15:0] first;
    logic [15:0] second;
  } slc_pair_word_type;

  typedef struct packed {
    logic        scrambler_enable;
    logic [5:0]  frames;
    logic [3:0]  lid_first;
    logic [3:0]  lid_second;
  } slc_link_cfg_type;

  typedef enum logic [1:0] {
    SLC_POLY7,
    SLC_POLY15,
    SLC_POLY23,
    SLC_POLY31
  } slc_poly_type;

  typedef enum logic [1:0] {
    SLC_ST_IDLE,
    SLC_ST_LOAD,
    SLC_ST_RUN
  } slc_link_state_type;

endpackage

/* common/slc_regs.svh */
// Register map, field positions and timing constants for the lane configuration block
// How it works
// - Scramble payload only while scrambler enable set
// - Frames per multiframe is field plus one
// - Program enable picks programmed over default IDs
// - First channel ID from bits 7-4
// - Second channel ID from bits 3-0
// - Polynomial code picks order 7/15/23/31
// - Test code six emits selected pseudo-random pattern
// - Sample LSBs stay zero unless flag enabled
// - Auto trigger ignores pins, else pin trigger
// - Ratio alarm when low/high ratio below three
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH

`define SLC_SCR_OFS        8'h25
`define SLC_MFL_OFS        8'h26
`define SLC_LIDC_OFS       8'h28
`define SLC_LIDV_OFS       8'h2D
`define SLC_POLY_OFS       8'h36
`define SLC_BURST_OFS      8'h37

`define SLC_REG_RESET      8'h00
`define SLC_SCR_WMASK      8'h80
`define SLC_MFL_WMASK      8'h1F
`define SLC_LIDC_WMASK     8'h08
`define SLC_LIDV_WMASK     8'hFF
`define SLC_BURST_WMASK    8'hF8

`define SLC_SCRAMBLER_ENABLE_BIT     7
`define SLC_K_MSB          4
`define SLC_K_LSB          0
`define SLC_LID_PROG_BIT   3
`define SLC_FIRST_CHANNEL_LANE_ID_MSB       7
`define SLC_FIRST_CHANNEL_LANE_ID_LSB       4
`define SLC_SECOND_CHANNEL_LANE_ID_MSB       3
`define SLC_SECOND_CHANNEL_LANE_ID_LSB       0
`define SLC_POLY_MSB       7
`define SLC_POLY_LSB       6
`define SLC_UPPER_EN_BIT   7
`define SLC_LOWER_EN_BIT   6
`define SLC_LOAD_BIT       5
`define SLC_TRIG_SEL_BIT   4
`define SLC_AUTO_BIT       3
`define SLC_RATIO_BIT      1
`define SLC_UPPER_LSB_POS  1
`define SLC_LOWER_LSB_POS  0

`define SLC_TEST_PRBS      3'h6
`define SLC_RATIO_MIN      30'h3
`define SLC_FRAMES_RESET   6'h01
`define SLC_DEF_LID_A      4'h0
`define SLC_DEF_LID_B      4'h1
`define SLC_DEF_LID_C      4'h2
`define SLC_DEF_LID_D      4'h3

`define SLC_CLK_PERIOD_NS  40
`define SLC_AUTO_TRIG_NS   400
`define SLC_AUTO_TRIG_CYC  ((`SLC_AUTO_TRIG_NS + `SLC_CLK_PERIOD_NS - 1) / `SLC_CLK_PERIOD_NS)

`define SLC_BUF_DEPTH      2'h2
`define SLC_SCR_TAP_A      13
`define SLC_SCR_TAP_B      14
`define SLC_SCR_RESET      15'h7FFF
`define SLC_PRBS_SEED      31'h7FFFFFFF
`define SLC_PRBS7_A        6
`define SLC_PRBS7_B        5
`define SLC_PRBS15_A       14
`define SLC_PRBS15_B       13
`define SLC_PRBS23_A       22
`define SLC_PRBS23_B       17
`define SLC_PRBS31_A       30
`define SLC_PRBS31_B       27

`endif

/* src/slc_lane_cfg.sv */
// Paged link configuration, burst-mode control and per-pair transmit word path
`timescale 1ns/10ps
`default_nettype none
`include "slc_regs.svh"
module slc_lane_cfg
  import slc_pkg::*;
(
  input  wire logic                    REF_CLK,        // Sample clock
  input  wire logic                    RST_N,          // Synchronous reset, active low
  input  wire logic                    REG_PAGE,       // Serializer pair page, 0 AB, 1 CD
  input  wire logic                    REG_WR,         // Register write strobe
  input  wire logic                    REG_RD,         // Register read strobe
  input  wire logic [7:0]              REG_ADDR,       // Register offset
  input  wire logic [7:0]              REG_WDATA,      // Write data
  output var  logic [7:0]              REG_RDATA,      // Read data
  output var  logic                    REG_RVALID,     // Read data valid
  input  wire logic                    LINK_INIT,      // Link (re)initialisation request
  output var  logic                    LINK_RUNNING,   // Settings applied, words flow
  output var  slc_link_cfg_type [1:0]  LINK_CFG,       // Applied settings per pair
  input  wire logic [2:0]              LINK_TEST_SEL,  // Link test pattern select
  input  wire slc_poly_type            POLY_SEL_IN,    // Test polynomial select
  input  wire logic [1:0]              HR_FLAG,        // High-resolution indicator per pair
  input  wire logic [1:0]              TRIG_PIN,       // Trigger pins, 0 AB, 1 CD
  output var  logic [1:0]              BURST_TRIG,     // Burst trigger per pair
  input  wire logic [27:0]             LOW_RES_COUNT,  // Low-resolution sample count
  input  wire logic [27:0]             HIGH_RES_COUNT, // High-resolution sample count
  input  wire logic [1:0]              IN_VALID,       // Sample word offered
  output var  logic [1:0]              IN_READY,       // Sample word taken
  input  wire slc_pair_word_type [1:0] IN_DATA,        // Sample word per pair
  output var  logic [1:0]              OUT_VALID,      // Lane word held
  input  wire logic [1:0]              OUT_READY,      // Lane word taken
  output var  slc_pair_word_type [1:0] OUT_DATA        // Lane word per pair
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // Self-synchronous scrambler, 1 + x^14 + x^15, MSB first
  function automatic logic [30:0] scr16(input logic [15:0] d, input logic [14:0] st_in);
    logic [14:0] st;
    logic [15:0] o;
    logic        b;
    st = st_in;
    o  = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      b    = d[i] ^ st[`SLC_SCR_TAP_A] ^ st[`SLC_SCR_TAP_B];
      o[i] = b;
      st   = {st[13:0], b};
    end
    return {st, o};
  endfunction

  // Receiver-side inverse, only read by the checks
  function automatic logic [15:0] descr16(input logic [15:0] s, input logic [14:0] st_in);
    logic [14:0] st;
    logic [15:0] d;
    st = st_in;
    d  = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      d[i] = s[i] ^ st[`SLC_SCR_TAP_A] ^ st[`SLC_SCR_TAP_B];
      st   = {st[13:0], s[i]};
    end
    return d;
  endfunction

  logic [1:0][7:0]    scr_reg;
  logic [1:0][7:0]    mfl_reg;
  logic [1:0][7:0]    lidc_reg;
  logic [1:0][7:0]    lidv_reg;
  logic [1:0][7:0]    burst_reg;
  logic [1:0]         ratio_inv;
  logic [1:0][27:0]   lo_cnt;
  logic [1:0][27:0]   hi_cnt;
  slc_link_state_type state;
  slc_link_state_type next_state;
  logic [7:0]         auto_cnt;

  wire sel_scr   = (REG_ADDR == `SLC_SCR_OFS);
  wire sel_mfl   = (REG_ADDR == `SLC_MFL_OFS);
  wire sel_lidc  = (REG_ADDR == `SLC_LIDC_OFS);
  wire sel_lidv  = (REG_ADDR == `SLC_LIDV_OFS);
  wire sel_poly  = (REG_ADDR == `SLC_POLY_OFS);
  wire sel_burst = (REG_ADDR == `SLC_BURST_OFS);
  wire [7:0] poly_rd  = 8'(POLY_SEL_IN) << `SLC_POLY_LSB;
  wire [7:0] burst_rd = burst_reg[REG_PAGE] | (8'(ratio_inv[REG_PAGE]) << `SLC_RATIO_BIT);
  // Unmapped offsets and reserved bits read as zero
  wire [7:0] rd_mux = sel_scr   ? scr_reg[REG_PAGE]  :
                      sel_mfl   ? mfl_reg[REG_PAGE]  :
                      sel_lidc  ? lidc_reg[REG_PAGE] :
                      sel_lidv  ? lidv_reg[REG_PAGE] :
                      sel_poly  ? poly_rd            :
                      sel_burst ? burst_rd           : `SLC_REG_RESET;
  wire auto_pulse = (auto_cnt == 8'(`SLC_AUTO_TRIG_CYC - 1));
  wire test_prbs  = (LINK_TEST_SEL == `SLC_TEST_PRBS);
  wire load_cfg   = (state == SLC_ST_LOAD);

  // Reserved bits are masked off so a careless write cannot reach the logic
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      scr_reg   <= {2{`SLC_REG_RESET}};
      mfl_reg   <= {2{`SLC_REG_RESET}};
      lidc_reg  <= {2{`SLC_REG_RESET}};
      lidv_reg  <= {2{`SLC_REG_RESET}};
      burst_reg <= {2{`SLC_REG_RESET}};
    end else if (REG_WR) begin
      if (sel_scr)   scr_reg[REG_PAGE]   <= REG_WDATA & `SLC_SCR_WMASK;
      if (sel_mfl)   mfl_reg[REG_PAGE]   <= REG_WDATA & `SLC_MFL_WMASK;
      if (sel_lidc)  lidc_reg[REG_PAGE]  <= REG_WDATA & `SLC_LIDC_WMASK;
      if (sel_lidv)  lidv_reg[REG_PAGE]  <= REG_WDATA & `SLC_LIDV_WMASK;
      if (sel_burst) burst_reg[REG_PAGE] <= REG_WDATA & `SLC_BURST_WMASK;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      REG_RDATA  <= `SLC_REG_RESET;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) REG_RDATA <= rd_mux;
    end
  end

  // Settings are copied to the link only in the load state
  always_comb begin
    case (state)
      SLC_ST_IDLE: next_state = LINK_INIT ? SLC_ST_LOAD : SLC_ST_IDLE;
      SLC_ST_LOAD: next_state = SLC_ST_RUN;
      SLC_ST_RUN:  next_state = LINK_INIT ? SLC_ST_LOAD : SLC_ST_RUN;
      default:     next_state = SLC_ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state    <= SLC_ST_IDLE;
      auto_cnt <= 8'h00;
    end else begin
      state    <= next_state;
      auto_cnt <= auto_pulse ? 8'h00 : 8'(auto_cnt + 8'h01);
    end
  end

  assign LINK_RUNNING = (state == SLC_ST_RUN);

  for (genvar g = 0; g < 2; g++) begin : g_pair
    localparam logic [3:0] DEF_FIRST  = (g == 0) ? `SLC_DEF_LID_A : `SLC_DEF_LID_C;
    localparam logic [3:0] DEF_SECOND = (g == 0) ? `SLC_DEF_LID_B : `SLC_DEF_LID_D;
    slc_pair_word_type prep;
    slc_pair_word_type push_data;
    logic [14:0]       scr_state;
    logic [15:0]       prbs_first;
    logic [15:0]       prbs_second;
    logic [30:0]       scr_a;
    logic [30:0]       scr_b;
    logic              buf_ready;
    logic              push;
    wire lid_prog  = lidc_reg[g][`SLC_LID_PROG_BIT];
    wire upper_en  = burst_reg[g][`SLC_UPPER_EN_BIT];
    wire lower_en  = burst_reg[g][`SLC_LOWER_EN_BIT];
    wire auto_en   = burst_reg[g][`SLC_AUTO_BIT];
    wire trig_sel  = burst_reg[g][`SLC_TRIG_SEL_BIT];
    wire pin_trig  = trig_sel ? TRIG_PIN[1 - g] : TRIG_PIN[g];
    wire ratio_low = 30'(lo_cnt[g]) < (30'(hi_cnt[g]) * `SLC_RATIO_MIN);
    wire scr_on    = LINK_CFG[g].scrambler_enable;

    assign push        = IN_VALID[g] & buf_ready & LINK_RUNNING;
    assign IN_READY[g] = buf_ready & LINK_RUNNING;

    // Low two bits carry the indicator only where enabled
    always_comb begin
      prep = IN_DATA[g];
      prep.first[`SLC_UPPER_LSB_POS]  = upper_en & HR_FLAG[g];
      prep.first[`SLC_LOWER_LSB_POS]  = lower_en & HR_FLAG[g];
      prep.second[`SLC_UPPER_LSB_POS] = upper_en & HR_FLAG[g];
      prep.second[`SLC_LOWER_LSB_POS] = lower_en & HR_FLAG[g];
      if (test_prbs) begin
        prep = {prbs_first, prbs_second};
      end
    end

    // One state per pair: the two lanes share it, so a receiver must descramble in order
    assign scr_a     = scr16(prep.first, scr_state);
    assign scr_b     = scr16(prep.second, scr_a[30:16]);
    assign push_data = scr_on ? {scr_a[15:0], scr_b[15:0]} : prep;

    always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
        scr_state <= `SLC_SCR_RESET;
      end else if (push && scr_on) begin
        scr_state <= scr_b[30:16];
      end
    end

    always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
        LINK_CFG[g] <= {1'b0, `SLC_FRAMES_RESET, DEF_FIRST, DEF_SECOND};
      end else if (load_cfg) begin
        LINK_CFG[g].scrambler_enable     <= scr_reg[g][`SLC_SCRAMBLER_ENABLE_BIT];
        LINK_CFG[g].frames     <= 6'(mfl_reg[g][`SLC_K_MSB:`SLC_K_LSB]) + 6'h01;
        LINK_CFG[g].lid_first  <= lid_prog ? lidv_reg[g][`SLC_FIRST_CHANNEL_LANE_ID_MSB:`SLC_FIRST_CHANNEL_LANE_ID_LSB]
                                           : DEF_FIRST;
        LINK_CFG[g].lid_second <= lid_prog ? lidv_reg[g][`SLC_SECOND_CHANNEL_LANE_ID_MSB:`SLC_SECOND_CHANNEL_LANE_ID_LSB]
                                           : DEF_SECOND;
      end
    end

    always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
        BURST_TRIG[g] <= 1'b0;
        ratio_inv[g]  <= 1'b0;
        lo_cnt[g]     <= 28'h0000000;
        hi_cnt[g]     <= 28'h0000000;
      end else begin
        BURST_TRIG[g] <= auto_en ? auto_pulse : pin_trig;
        ratio_inv[g]  <= ratio_low;
        if (burst_reg[g][`SLC_LOAD_BIT]) begin
          lo_cnt[g] <= LOW_RES_COUNT;
          hi_cnt[g] <= HIGH_RES_COUNT;
        end
      end
    end

    slc_prbs_gen u_prbs_first (
      .clk      (REF_CLK),
      .rst_n    (RST_N),
      .poly_sel (POLY_SEL_IN),
      .advance  (push && test_prbs),
      .word     (prbs_first)
    );

    slc_prbs_gen u_prbs_second (
      .clk      (REF_CLK),
      .rst_n    (RST_N),
      .poly_sel (POLY_SEL_IN),
      .advance  (push && test_prbs),
      .word     (prbs_second)
    );

    slc_pair_buf u_buf (
      .clk       (REF_CLK),
      .rst_n     (RST_N),
      .in_valid  (IN_VALID[g] & LINK_RUNNING),
      .in_ready  (buf_ready),
      .in_data   (push_data),
      .out_valid (OUT_VALID[g]),
      .out_ready (OUT_READY[g]),
      .out_data  (OUT_DATA[g])
    );

    a_scr_bypass_pass: assert property (
      push && !scr_on |-> push_data == prep) else $error("payload changed with scrambler off");
    a_scr_inverts_ok: assert property (
      push && scr_on |-> descr16(push_data.first, scr_state) == prep.first)
      else $error("scrambled word does not descramble");
    a_frames_plus_one: assert property (
      load_cfg |=> LINK_CFG[g].frames == 6'($past(mfl_reg[g][`SLC_K_MSB:`SLC_K_LSB])) + 6'h01)
      else $error("frames per multiframe not field plus one");
    a_lid_default_use: assert property (
      load_cfg && !lid_prog |=> LINK_CFG[g].lid_first == DEF_FIRST
                               && LINK_CFG[g].lid_second == DEF_SECOND)
      else $error("default lane identifier not applied");
    a_lid_first_prog: assert property (
      load_cfg && lid_prog |=> LINK_CFG[g].lid_first
                               == $past(lidv_reg[g][`SLC_FIRST_CHANNEL_LANE_ID_MSB:`SLC_FIRST_CHANNEL_LANE_ID_LSB]))
      else $error("first channel identifier wrong");
    a_lid_second_prog: assert property (
      load_cfg && lid_prog |=> LINK_CFG[g].lid_second
                               == $past(lidv_reg[g][`SLC_SECOND_CHANNEL_LANE_ID_MSB:`SLC_SECOND_CHANNEL_LANE_ID_LSB]))
      else $error("second channel identifier wrong");
    a_prbs_word_out: assert property (
      push && test_prbs && !scr_on |-> push_data == {prbs_first, prbs_second})
      else $error("test word is not the pattern");
    a_lsb_stuck_zero: assert property (
      push && !test_prbs && !scr_on && !upper_en && !lower_en
      |-> push_data.first[1:0] == 2'h0 && push_data.second[1:0] == 2'h0)
      else $error("sample low bits not zero");
    a_trig_auto_pin: assert property (
      auto_en ##1 auto_en |-> BURST_TRIG[g] == $past(auto_pulse))
      else $error("auto trigger does not follow internal pulse");
    a_trig_from_pin: assert property (
      !auto_en && !trig_sel ##1 1'b1 |-> BURST_TRIG[g] == $past(TRIG_PIN[g]))
      else $error("pin trigger not passed");
    a_ratio_alarm_set: assert property (
      ##1 ratio_inv[g] == $past(lo_cnt[g] < hi_cnt[g] * 28'h3 || hi_cnt[g] > 28'h5555555))
      else $error("ratio alarm wrong");
    a_cfg_stable_run: assert property (
      LINK_RUNNING && !$past(load_cfg) |-> $stable(LINK_CFG[g]))
      else $error("link settings changed outside initialisation");

    c_scr_push: cover property (push && scr_on);
    c_prbs_push: cover property (push && test_prbs);
    c_buf_full: cover property (IN_VALID[g] && LINK_RUNNING && !buf_ready);
  end

  a_poly_read_back: assert property (
    REG_RD && sel_poly |=> REG_RDATA[`SLC_POLY_MSB:`SLC_POLY_LSB] == $past(POLY_SEL_IN)
                           && REG_RDATA[5:0] == 6'h00)
    else $error("polynomial field read wrong");
  a_rsvd_read_zero: assert property (
    REG_RD && sel_scr |=> REG_RDATA[6:0] == 7'h00) else $error("reserved bits not zero");
  c_reinit: cover property (LINK_RUNNING && LINK_INIT ##1 load_cfg ##1 LINK_RUNNING);
endmodule
`default_nettype wire

/* src/slc_pair_buf.sv */
// Two-entry buffer for one lane pair word stream
`timescale 1ns/10ps
`default_nettype none
`include "slc_regs.svh"
module slc_pair_buf
  import slc_pkg::*;
(
  input  wire logic              clk,       // Sample clock
  input  wire logic              rst_n,     // Synchronous reset, active low
  input  wire logic              in_valid,  // Word offered
  output var  logic              in_ready,  // Room for a word
  input  wire slc_pair_word_type in_data,   // Word in
  output var  logic              out_valid, // Word held
  input  wire logic              out_ready, // Receiver takes word
  output var  slc_pair_word_type out_data   // Oldest word
);
  slc_pair_word_type [1:0] mem;
  logic [1:0]              count;
  logic                    wr_ptr;
  logic                    rd_ptr;
  wire                     push = in_valid & in_ready;
  wire                     pop  = out_valid & out_ready;

  assign in_ready  = (count != `SLC_BUF_DEPTH);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count  <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      mem    <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

  a_buf_never_over: assert property (@(posedge clk) disable iff (!rst_n)
    count <= `SLC_BUF_DEPTH) else $error("buffer count above depth");
  a_buf_stall_keep: assert property (@(posedge clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("held word changed under stall");
endmodule
`default_nettype wire

/* src/slc_prbs_gen.sv */
// Pseudo-random word generator with selectable polynomial order
`timescale 1ns/10ps
`default_nettype none
`include "slc_regs.svh"
module slc_prbs_gen
  import slc_pkg::*;
(
  input  wire logic         clk,      // Sample clock
  input  wire logic         rst_n,    // Synchronous reset, active low
  input  wire slc_poly_type poly_sel, // Polynomial order
  input  wire logic         advance,  // Step to the next word
  output var  logic [15:0]  word      // Current pattern word
);
  logic [30:0] lfsr;
  logic [30:0] next_lfsr;
  logic [15:0] next_word;

  // Sixteen serial steps per word, first bit in the MSB
  always_comb begin
    logic [30:0] st;
    logic        fb;
    st        = lfsr;
    fb        = 1'b0;
    next_word = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      case (poly_sel)
        SLC_POLY7:  fb = st[`SLC_PRBS7_A] ^ st[`SLC_PRBS7_B];
        SLC_POLY15: fb = st[`SLC_PRBS15_A] ^ st[`SLC_PRBS15_B];
        SLC_POLY23: fb = st[`SLC_PRBS23_A] ^ st[`SLC_PRBS23_B];
        SLC_POLY31: fb = st[`SLC_PRBS31_A] ^ st[`SLC_PRBS31_B];
        default:    fb = st[`SLC_PRBS7_A] ^ st[`SLC_PRBS7_B];
      endcase
      next_word[i] = fb;
      st = {st[29:0], fb};
    end
    next_lfsr = st;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lfsr <= `SLC_PRBS_SEED;
      word <= 16'h0000;
    end else if (advance) begin
      lfsr <= next_lfsr;
      word <= next_word;
    end
  end

  a_prbs_word_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !advance |=> $stable(word)) else $error("pattern word moved without advance");
  a_prbs_not_stuck: assert property (@(posedge clk) disable iff (!rst_n)
    advance |=> lfsr != 31'h00000000) else $error("pattern register locked at zero");
endmodule
`default_nettype wire

/* verif/slc_rx_model.sv */
// Lane receiver model that takes words promptly, slowly or stalls
`timescale 1ns/10ps
`default_nettype none
module slc_rx_model (
  input  wire logic clk,   // Sample clock
  input  wire logic stall, // Refuse every word
  input  wire logic slow,  // Accept every other cycle
  output var  logic ready  // Word taken
);
  initial ready = 1'b0;
  // Changes just after the falling edge so the design samples it settled
  always @(negedge clk) begin
    ready <= !stall && (!slow || !ready);
  end
endmodule
`default_nettype wire

/* verif/tb_slc_lane_cfg.sv */
// Self-checking bench for the lane configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_slc_lane_cfg
  import slc_pkg::*;
;
  logic REF_CLK = 0, RST_N = 0, REG_PAGE = 0, REG_WR = 0, REG_RD = 0;
  logic LINK_INIT = 0, LINK_RUNNING, REG_RVALID;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  logic [2:0] LINK_TEST_SEL = 3'h0;
  logic [1:0] HR_FLAG = 2'h1, TRIG_PIN = 2'h0, IN_VALID = 2'h0, stall = 2'h0, slow = 2'h0;
  logic [1:0] BURST_TRIG, IN_READY, OUT_VALID, OUT_READY;
  logic [27:0] LOW_RES_COUNT = 28'h0, HIGH_RES_COUNT = 28'h0;
  slc_poly_type POLY_SEL_IN = SLC_POLY23;
  slc_link_cfg_type [1:0] LINK_CFG;
  slc_pair_word_type [1:0] IN_DATA = '0, OUT_DATA;
  int errors = 0, total_checks = 0;
  logic [31:0] q0[$];
  logic [14:0] sst = 15'h7FFF;
  logic [7:0] ofs [6] = '{8'h25, 8'h26, 8'h28, 8'h2D, 8'h36, 8'h37};
  logic [7:0] msk [6] = '{8'h80, 8'h1F, 8'h08, 8'hFF, 8'h80, 8'hF8};
  logic [31:0] wd [3] = '{32'h12345677, 32'hBEEF0001, 32'h0F0FF0F3};

  slc_lane_cfg dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_PAGE(REG_PAGE),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .LINK_INIT(LINK_INIT),
    .LINK_RUNNING(LINK_RUNNING), .LINK_CFG(LINK_CFG), .LINK_TEST_SEL(LINK_TEST_SEL),
    .POLY_SEL_IN(POLY_SEL_IN), .HR_FLAG(HR_FLAG), .TRIG_PIN(TRIG_PIN),
    .BURST_TRIG(BURST_TRIG), .LOW_RES_COUNT(LOW_RES_COUNT), .HIGH_RES_COUNT(HIGH_RES_COUNT),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_DATA(IN_DATA), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA));
  slc_rx_model rx_u0 (.clk(REF_CLK), .stall(stall[0]), .slow(slow[0]), .ready(OUT_READY[0]));
  slc_rx_model rx_u1 (.clk(REF_CLK), .stall(stall[1]), .slow(slow[1]), .ready(OUT_READY[1]));

  initial forever #20 REF_CLK = !REF_CLK;
  always @(posedge REF_CLK) if (OUT_VALID[0] && OUT_READY[0]) q0.push_back(OUT_DATA[0]);

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Upper flag enabled with the flag high: bit 1 of each lane set, bit 0 cleared
  function automatic logic [31:0] lb(input logic [31:0] w);
    return (w & 32'hFFFCFFFC) | 32'h00020002;
  endfunction
  // Self-synchronous scrambler, MSB first, state carried across words
  function automatic logic [31:0] scr(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      scr[i] = w[i] ^ sst[13] ^ sst[14];
      sst = {sst[13:0], scr[i]};
    end
  endfunction
  task automatic acc(input logic rd, input logic p, input logic [7:0] a, input logic [7:0] d);
    @(negedge REF_CLK);
    REG_PAGE = p;
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = !rd;
    REG_RD = rd;
    @(negedge REF_CLK);
    REG_WR = 0;
    REG_RD = 0;
    if (rd) chk("rvalid", REG_RVALID, 1);
    if (rd) chk("rdata", REG_RDATA, d);
  endtask
  task automatic push(input logic [31:0] d);
    int n = 0;
    @(negedge REF_CLK);
    IN_DATA[0] = d;
    IN_VALID[0] = 1;
    while (IN_READY[0] !== 1'b1 && n < 40) begin
      @(negedge REF_CLK);
      n++;
    end
    @(negedge REF_CLK);
    IN_VALID[0] = 0;
  endtask
  task automatic drain(input int k);
    for (int n = 0; n < 40 && q0.size() < k; n++) @(negedge REF_CLK);
    chk("count", q0.size(), k);
  endtask
  task automatic init_link;
    @(negedge REF_CLK);
    LINK_INIT = 1;
    @(negedge REF_CLK);
    LINK_INIT = 0;
    chk("running_load", LINK_RUNNING, 0);
    @(negedge REF_CLK);
    chk("running", LINK_RUNNING, 1);
  endtask

  task automatic t_regs;
    chk("cfg1_reset", 32'(LINK_CFG[1]), 32'({1'b0, 6'h01, 4'h2, 4'h3}));
    for (int i = 0; i < 6; i++) begin
      acc(1, 1, ofs[i], i == 4 ? 8'h80 : 8'h00);
      acc(0, 1, ofs[i], 8'hFF);
      acc(1, 1, ofs[i], msk[i]);
    end
    acc(1, 1, 8'h30, 8'h00);
    for (int c = 0; c < 4; c++) begin
      POLY_SEL_IN = slc_poly_type'(c[1:0]);
      acc(1, 0, 8'h36, {c[1:0], 6'h00});
    end
  endtask
  task automatic t_init;
    acc(0, 0, 8'h26, 8'h0F);
    acc(0, 0, 8'h28, 8'h08);
    acc(0, 0, 8'h2D, 8'hA5);
    chk("cfg0_held", 32'(LINK_CFG[0]), 32'({1'b0, 6'h01, 4'h0, 4'h1}));
    chk("ready_idle", IN_READY, 2'h0);
    init_link();
    chk("cfg0", 32'(LINK_CFG[0]), 32'({1'b0, 6'h10, 4'hA, 4'h5}));
    chk("cfg1", 32'(LINK_CFG[1]), 32'({1'b1, 6'h20, 4'hF, 4'hF}));
    // Pair CD: both flag enables set, flag low, so both low bits stay zero
    @(negedge REF_CLK);
    IN_DATA[1] = wd[1];
    IN_VALID[1] = 1;
    chk("ready1", IN_READY[1], 1);
    @(negedge REF_CLK);
    IN_VALID[1] = 0;
    chk("held1", OUT_VALID[1], 1);
    chk("out1", OUT_DATA[1], scr(wd[1] & 32'hFFFCFFFC));
    sst = 15'h7FFF;
  endtask
  task automatic t_stream;
    acc(0, 0, 8'h37, 8'h80);
    stall[0] = 1;
    push(wd[0]);
    push(wd[1]);
    // Let an edge pass so valid is never lowered and raised in one time step
    @(negedge REF_CLK) IN_VALID[0] = 1;
    repeat (3) @(negedge REF_CLK) chk("full", IN_READY[0], 0);
    chk("held", OUT_VALID[0], 1);
    IN_VALID[0] = 0;
    stall[0] = 0;
    slow[0] = 1;
    push(wd[2]);
    drain(3);
    for (int i = 0; i < 3; i++) chk("word", q0[i], lb(wd[i]));
    q0.delete();
  endtask
  task automatic t_scr;
    acc(0, 0, 8'h25, 8'h80);
    push(wd[0]);
    drain(1);
    chk("plain", q0[0], lb(wd[0]));
    init_link();
    push(wd[1]);
    push(wd[2]);
    drain(3);
    chk("scr1", q0[1], scr(lb(wd[1])));
    chk("scr2", q0[2], scr(lb(wd[2])));
    LINK_TEST_SEL = 3'h6;
    push(wd[0]);
    push(wd[0]);
    drain(5);
    chk("pattern", q0[3] === q0[4], 0);
    chk("pattern0", q0[3], scr(32'h00000000));
    LINK_TEST_SEL = 3'h0;
  endtask
  task automatic t_trig;
    int k = 0;
    int k1 = 0;
    acc(0, 0, 8'h37, 8'h00);
    TRIG_PIN = 2'b01;
    @(negedge REF_CLK) chk("pin", BURST_TRIG[0], 1);
    acc(0, 0, 8'h37, 8'h10);
    TRIG_PIN = 2'b10;
    @(negedge REF_CLK) chk("pin_sel", BURST_TRIG[0], 1);
    acc(0, 0, 8'h37, 8'h08);
    TRIG_PIN = 2'b11;
    repeat (20) @(negedge REF_CLK) begin
      k += int'(BURST_TRIG[0] === 1'b1);
      k1 += int'(BURST_TRIG[1] === 1'b1);
    end
    chk("auto", k, 2);
    chk("auto1", k1, 2);
    LOW_RES_COUNT = 28'h5;
    HIGH_RES_COUNT = 28'h2;
    repeat (3) @(negedge REF_CLK);
    acc(1, 1, 8'h37, 8'hFA);
    LOW_RES_COUNT = 28'h6;
    repeat (3) @(negedge REF_CLK);
    acc(1, 1, 8'h37, 8'hF8);
  endtask

  task automatic complete_run;
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge REF_CLK);
    RST_N = 1;
    t_regs();
    t_init();
    t_stream();
    t_scr();
    t_trig();
    complete_run();
  end
  // Whole sequence needs well under 2000 cycles
  initial begin
    #400000;
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
